// [logic/jisp_pkg.sv]
// Constants, encodings and state types shared by the programming sequencer
package jisp_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int IR_W = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int DR_W = 32;
    localparam int IO_W = 16;
    localparam int CMD_W = 3;
    localparam int TIMER_W = 24;
    localparam int DRLEN_W = 5;

    // ----------------------------------------------------------------
    // Instruction codes loaded through the test port
    // ----------------------------------------------------------------
    localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
    localparam logic [IR_W-1:0] IR_ENTER = 4'h2;
    localparam logic [IR_W-1:0] IR_EXIT = 4'h3;
    localparam logic [IR_W-1:0] IR_ERASE = 4'h4;
    localparam logic [IR_W-1:0] IR_ADDRESS = 4'h5;
    localparam logic [IR_W-1:0] IR_PROGRAM = 4'h6;
    localparam logic [IR_W-1:0] IR_READ = 4'h7;
    localparam logic [IR_W-1:0] IR_DONE = 4'h8;
    localparam logic [IR_W-1:0] IR_STATUS = 4'h9;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

    // Shift lengths minus one, per data register
    localparam logic [DRLEN_W-1:0] LEN_ID = 5'h1f;
    localparam logic [DRLEN_W-1:0] LEN_ADDR = 5'h07;
    localparam logic [DRLEN_W-1:0] LEN_DATA = 5'h0f;
    localparam logic [DRLEN_W-1:0] LEN_STAT = 5'h02;
    localparam logic [DRLEN_W-1:0] LEN_BYP = 5'h00;

    // Silicon identity; the value is arbitrary
    localparam logic [DR_W-1:0] SILICON_ID = 32'h5a3c_0001;

    // ----------------------------------------------------------------
    // Commands passed from the test-clock side to the system side
    // ----------------------------------------------------------------
    localparam logic [CMD_W-1:0] CMD_NONE = 3'h0;
    localparam logic [CMD_W-1:0] CMD_ENTER = 3'h1;
    localparam logic [CMD_W-1:0] CMD_EXIT = 3'h2;
    localparam logic [CMD_W-1:0] CMD_ERASE = 3'h3;
    localparam logic [CMD_W-1:0] CMD_PROG = 3'h4;
    localparam logic [CMD_W-1:0] CMD_READ = 3'h5;
    localparam logic [CMD_W-1:0] CMD_DONE = 3'h6;

    // ----------------------------------------------------------------
    // Timing, each time in its own unit and the derived cycle count
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int ENTER_TIME_MS = 1;
    localparam int EXIT_TIME_MS = 1;
    localparam int ERASE_TIME_MS = 100;
    localparam int PROG_TIME_US = 10;
    localparam int READ_TIME_US = 1;
    localparam int ENTER_CYCLES = ENTER_TIME_MS * 1000 * CLK_MHZ;
    localparam int EXIT_CYCLES = EXIT_TIME_MS * 1000 * CLK_MHZ;
    localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int READ_CYCLES = READ_TIME_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // Reset and erased values
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
    localparam logic DONE_RESET = 1'b0;

    typedef enum logic [3:0] {
        TAP_EX2_DR = 4'h0, TAP_EX1_DR = 4'h1, TAP_SH_DR = 4'h2, TAP_PA_DR = 4'h3,
        TAP_SEL_IR = 4'h4, TAP_UPD_DR = 4'h5, TAP_CAP_DR = 4'h6, TAP_SEL_DR = 4'h7,
        TAP_EX2_IR = 4'h8, TAP_EX1_IR = 4'h9, TAP_SH_IR = 4'ha, TAP_PA_IR = 4'hb,
        TAP_IDLE = 4'hc, TAP_UPD_IR = 4'hd, TAP_CAP_IR = 4'he, TAP_RESET = 4'hf
    } jisp_tap_e;

    typedef enum logic [2:0] {
        SEQ_USER = 3'h0, SEQ_ENTER = 3'h1, SEQ_ACTIVE = 3'h2, SEQ_ERASE = 3'h3,
        SEQ_PROG = 3'h4, SEQ_READ = 3'h5, SEQ_EXIT = 3'h6
    } jisp_seq_e;

endpackage : jisp_pkg

// [logic/jisp_tap.sv]
// Test-port state machine running on the test clock
`timescale 1ns/1ps
module jisp_tap (
    input wire logic tck,
    input wire logic rst_n,
    input wire logic tms,
    output jisp_pkg::jisp_tap_e state
);
    import jisp_pkg::*;

    jisp_tap_e next_state;

    // Standard sixteen-state walk steered by the mode select pin
    always_comb begin
        case (state)
            TAP_RESET: next_state = tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: next_state = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: next_state = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: next_state = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: next_state = tms ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR: next_state = tms ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: next_state = tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: next_state = tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: next_state = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: next_state = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: next_state = tms ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR: next_state = tms ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: next_state = tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
            default: next_state = TAP_RESET;
        endcase
    end

    // State register, synchronous reset on the test clock
    always_ff @(posedge tck) begin
        if (!rst_n) begin
            state <= TAP_RESET;
        end else begin
            state <= next_state;
        end
    end

endmodule : jisp_tap

// [logic/jisp_cell_mem.sv]
// Nonvolatile cell array model with registered read data
`timescale 1ns/1ps
module jisp_cell_mem (
    input wire logic clk,
    input wire logic we,
    input wire logic [jisp_pkg::ADDR_W-1:0] addr,
    input wire logic [jisp_pkg::DATA_W-1:0] wdata,
    output logic [jisp_pkg::DATA_W-1:0] rdata
);
    import jisp_pkg::*;

    logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

    // Write port; contents survive reset like real cells
    always_ff @(posedge clk) begin
        if (we) begin
            cells[addr] <= wdata;
        end
    end

    // Read data always from a register
    always_ff @(posedge clk) begin
        rdata <= cells[addr];
    end

endmodule : jisp_cell_mem

// [logic/jisp_sequencer.sv]
// In-system programming sequencer: test port, command crossing, pulses, pin hold-off
//
// Summary of operation
// - While programming mode is active, user pins float with a weak pull-up.
// - Completion bit is written last; until set, user pins never drive.
// - Instructions, addresses, data shift in on TDI; data returns on TDO.
// - Enter stage moves pins into programming mode over one millisecond.
// - Exit stage returns pins to user mode over one millisecond.
`timescale 1ns/1ps
module jisp_sequencer #(
    parameter int ENTER_CYC = jisp_pkg::ENTER_CYCLES,
    parameter int EXIT_CYC = jisp_pkg::EXIT_CYCLES,
    parameter int ERASE_CYC = jisp_pkg::ERASE_CYCLES
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE,
    input wire logic [jisp_pkg::IO_W-1:0] USER_DATA,
    input wire logic [jisp_pkg::IO_W-1:0] USER_OE,
    output logic [jisp_pkg::IO_W-1:0] IO_OUT,
    output logic [jisp_pkg::IO_W-1:0] IO_OE,
    output logic [jisp_pkg::IO_W-1:0] IO_PULLUP,
    output logic PROG_MODE
);
    import jisp_pkg::*;

    // ----------------------------------------------------------------
    // Test-clock domain
    // ----------------------------------------------------------------
    logic rst_t1, rst_t2;
    jisp_tap_e tap;
    logic [IR_W-1:0] ir, ir_shift;
    logic [DR_W-1:0] dr_shift;
    logic [ADDR_W-1:0] addr_hold;
    logic [DATA_W-1:0] data_hold;
    logic [CMD_W-1:0] cmd_hold;
    logic req_tgl;
    logic ack_t1, ack_t2;
    logic act_t1, act_t2, done_t1, done_t2;

    // Reset into the test-clock domain; test clock must run while RESET_N is low
    always_ff @(posedge TCK) begin
        rst_t1 <= RESET_N;
        rst_t2 <= rst_t1;
    end

    jisp_tap u_tap (
        .tck(TCK),
        .rst_n(rst_t2),
        .tms(TMS),
        .state(tap)
    );

    // Decode of the data register chosen by the current instruction
    wire busy = req_tgl ^ ack_t2;
    wire sel_id = (ir == IR_IDCODE);
    wire sel_addr = (ir == IR_ADDRESS);
    wire sel_data = (ir == IR_PROGRAM) || (ir == IR_READ);
    wire sel_stat = (ir == IR_STATUS);
    wire [DRLEN_W-1:0] dr_top = sel_id ? LEN_ID : sel_addr ? LEN_ADDR :
                                sel_data ? LEN_DATA : sel_stat ? LEN_STAT : LEN_BYP;
    wire [DR_W-1:0] tdi_mask = 32'h0000_0001 << dr_top;
    wire [DR_W-1:0] dr_next = ({1'b0, dr_shift[DR_W-1:1]} & ~tdi_mask)
                              | (TDI ? tdi_mask : 32'h0000_0000);
    logic [DATA_W-1:0] rd_word;
    wire [DR_W-1:0] dr_capture =
        sel_id ? SILICON_ID :
        sel_addr ? {{(DR_W-ADDR_W){1'b0}}, addr_hold} :
        (ir == IR_READ) ? {{(DR_W-DATA_W){1'b0}}, rd_word} :
        (ir == IR_PROGRAM) ? {{(DR_W-DATA_W){1'b0}}, data_hold} :
        sel_stat ? {29'h0000_0000, done_t2, act_t2, busy} : 32'h0000_0000;

    // Commands launched on update; ignored while the system side is busy
    wire [CMD_W-1:0] ir_cmd = (ir_shift == IR_ENTER) ? CMD_ENTER :
                              (ir_shift == IR_EXIT) ? CMD_EXIT :
                              (ir_shift == IR_ERASE) ? CMD_ERASE :
                              (ir_shift == IR_READ) ? CMD_READ :
                              (ir_shift == IR_DONE) ? CMD_DONE : CMD_NONE;
    wire launch_ir = (tap == TAP_UPD_IR) && (ir_cmd != CMD_NONE) && !busy;
    wire launch_prog = (tap == TAP_UPD_DR) && (ir == IR_PROGRAM) && !busy;
    wire launch = launch_ir || launch_prog;
    wire [CMD_W-1:0] launch_cmd = launch_prog ? CMD_PROG : ir_cmd;

    // Instruction shift and update
    always_ff @(posedge TCK) begin
        if (!rst_t2 || tap == TAP_RESET) begin
            ir_shift <= IR_CAPTURE;
            ir <= IR_IDCODE;
        end else begin
            if (tap == TAP_CAP_IR) ir_shift <= IR_CAPTURE;
            if (tap == TAP_SH_IR) ir_shift <= {TDI, ir_shift[IR_W-1:1]};
            if (tap == TAP_UPD_IR) ir <= ir_shift;
        end
    end

    // Data register capture and shift
    always_ff @(posedge TCK) begin
        if (!rst_t2) begin
            dr_shift <= 32'h0000_0000;
        end else if (tap == TAP_CAP_DR) begin
            dr_shift <= dr_capture;
        end else if (tap == TAP_SH_DR) begin
            dr_shift <= dr_next;
        end
    end

    // Address and data holding registers, frozen while a command runs
    always_ff @(posedge TCK) begin
        if (!rst_t2) begin
            addr_hold <= '0;
            data_hold <= '0;
        end else if (tap == TAP_UPD_DR && !busy) begin
            if (sel_addr) addr_hold <= dr_shift[ADDR_W-1:0];
            if (ir == IR_PROGRAM) data_hold <= dr_shift[DATA_W-1:0];
        end
    end

    // Request toggle towards the system clock
    always_ff @(posedge TCK) begin
        if (!rst_t2) begin
            cmd_hold <= CMD_NONE;
            req_tgl <= 1'b0;
        end else if (launch) begin
            cmd_hold <= launch_cmd;
            req_tgl <= ~req_tgl;
        end
    end

    logic ack_tgl, active_flag, done_bit;

    // Acknowledge and status levels brought onto the test clock
    always_ff @(posedge TCK) begin
        ack_t1 <= ack_tgl;
        ack_t2 <= ack_t1;
        act_t1 <= active_flag;
        act_t2 <= act_t1;
        done_t1 <= done_bit;
        done_t2 <= done_t1;
    end

    // Serial out changes on the falling test-clock edge, driven only while shifting
    always_ff @(negedge TCK) begin
        if (!rst_t2) begin
            TDO <= 1'b0;
            TDO_OE <= 1'b0;
        end else begin
            TDO <= (tap == TAP_SH_IR) ? ir_shift[0] : dr_shift[0];
            TDO_OE <= (tap == TAP_SH_IR) || (tap == TAP_SH_DR);
        end
    end

    // ----------------------------------------------------------------
    // System-clock domain
    // ----------------------------------------------------------------
    logic req_s1, req_s2, req_s3;
    jisp_seq_e state, next_state;
    logic [TIMER_W-1:0] timer, next_timer;
    logic [ADDR_W:0] walk;
    logic next_ack;
    logic [DATA_W-1:0] mem_rdata;

    // Request toggle crossing; edge found between second and third stage
    always_ff @(posedge CLK) begin
        req_s1 <= req_tgl;
        req_s2 <= req_s1;
        req_s3 <= req_s2;
    end

    // Holding registers are stable between request and acknowledge
    wire new_req = req_s2 ^ req_s3;
    wire timer_end = (timer == '0);
    wire erasing = (state == SEQ_ERASE) && !walk[ADDR_W];
    wire prog_write = (state == SEQ_PROG) && timer_end;
    wire mem_we = erasing || prog_write;
    wire [ADDR_W-1:0] mem_addr = erasing ? walk[ADDR_W-1:0] : addr_hold;
    wire [DATA_W-1:0] mem_wdata = erasing ? ERASED_WORD : data_hold;
    wire pins_held = (state != SEQ_USER) || !done_bit;

    // Stage sequencing; every request is acknowledged, illegal ones at once
    always_comb begin
        next_state = state;
        next_timer = timer_end ? timer : timer - 1'b1;
        next_ack = 1'b0;
        case (state)
            SEQ_USER: begin
                if (new_req && cmd_hold == CMD_ENTER) begin
                    next_state = SEQ_ENTER;
                    next_timer = TIMER_W'(ENTER_CYC - 1);
                end else if (new_req) begin
                    next_ack = 1'b1;
                end
            end
            SEQ_ENTER, SEQ_EXIT, SEQ_ERASE, SEQ_PROG, SEQ_READ: begin
                if (timer_end) begin
                    next_state = (state == SEQ_EXIT) ? SEQ_USER : SEQ_ACTIVE;
                    next_ack = 1'b1;
                end
            end
            SEQ_ACTIVE: begin
                if (new_req) begin
                    case (cmd_hold)
                        CMD_EXIT: begin
                            next_state = SEQ_EXIT;
                            next_timer = TIMER_W'(EXIT_CYC - 1);
                        end
                        CMD_ERASE: begin
                            next_state = SEQ_ERASE;
                            next_timer = TIMER_W'(ERASE_CYC - 1);
                        end
                        CMD_PROG: begin
                            next_state = SEQ_PROG;
                            next_timer = TIMER_W'(PROG_CYCLES - 1);
                        end
                        CMD_READ: begin
                            next_state = SEQ_READ;
                            next_timer = TIMER_W'(READ_CYCLES - 1);
                        end
                        default: next_ack = 1'b1;
                    endcase
                end
            end
            default: next_state = SEQ_USER;
        endcase
    end

    // Sequencer state and pulse timer
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            state <= SEQ_USER;
            timer <= '0;
            ack_tgl <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            ack_tgl <= ack_tgl ^ next_ack;
        end
    end

    // Erase walk writes every cell once inside the erase pulse
    always_ff @(posedge CLK) begin
        if (!RESET_N || state != SEQ_ERASE) begin
            walk <= '0;
        end else if (!walk[ADDR_W]) begin
            walk <= walk + 1'b1;
        end
    end

    // Completion bit: set by its own command, cleared by erase or any later program
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            done_bit <= DONE_RESET;
        end else if (state == SEQ_ERASE || state == SEQ_PROG) begin
            done_bit <= 1'b0;
        end else if (state == SEQ_ACTIVE && new_req && cmd_hold == CMD_DONE) begin
            done_bit <= 1'b1;
        end
    end

    // Read pulse result, kept until the next read finishes
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            rd_word <= '0;
        end else if (state == SEQ_READ && timer_end) begin
            rd_word <= mem_rdata;
        end
    end

    jisp_cell_mem u_cells (
        .clk(CLK),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // User pins: released as soon as entry starts, returned only after exit ends
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            IO_OUT <= '0;
            IO_OE <= '0;
            IO_PULLUP <= '1;
            PROG_MODE <= 1'b0;
            active_flag <= 1'b0;
        end else begin
            IO_OUT <= pins_held ? '0 : USER_DATA;
            IO_OE <= pins_held ? '0 : USER_OE;
            IO_PULLUP <= {IO_W{pins_held}};
            PROG_MODE <= (next_state != SEQ_USER);
            // Rises on the same edge as the enter acknowledge and falls on the same edge as the exit acknowledge, so status never shows a stale mode
            active_flag <= (next_state != SEQ_USER) && (next_state != SEQ_ENTER);
        end
    end

endmodule : jisp_sequencer

// [bench/jisp_seq_properties.sv]
// Concurrent checks on pin hold-off, mode timing and test-port shifting
`timescale 1ns/1ps
module jisp_seq_properties #(
    parameter int ENTER_CYC = 50,
    parameter int EXIT_CYC = 50
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDO_OE,
    input wire logic [jisp_pkg::IO_W-1:0] IO_OE,
    input wire logic [jisp_pkg::IO_W-1:0] IO_PULLUP,
    input wire logic PROG_MODE
);
    int run_cnt;
    // ----------
    // Properties
    // ----------
    // Length of the current programming spell; a short one means a wait was cut
    always_ff @(posedge CLK) begin
        run_cnt <= (!RESET_N || !PROG_MODE) ? 0 : run_cnt + 1;
    end
    sequence pins_float;
        (IO_OE == '0) && (IO_PULLUP == '1);
    endsequence
    sequence tap_reset_walk;
        TMS [*5];
    endsequence
    AST_MODE_FLOAT: assert property (@(posedge CLK) disable iff (!RESET_N)
        PROG_MODE |=> pins_float)
        else $error("pins not floating in programming mode");
    AST_RESET_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N)
        $rose(RESET_N) |-> pins_float [*8])
        else $error("pins driven before completion bit set");
    AST_DRIVE_USER: assert property (@(posedge CLK) disable iff (!RESET_N)
        (IO_OE != '0) |-> !$past(PROG_MODE))
        else $error("pins driven outside user mode");
    AST_MODE_SPELL: assert property (@(posedge CLK) disable iff (!RESET_N)
        $fell(PROG_MODE) |-> (run_cnt >= ENTER_CYC + EXIT_CYC))
        else $error("programming mode shorter than enter plus exit time");
    AST_EXIT_HELD: assert property (@(posedge CLK) disable iff (!RESET_N)
        $fell(PROG_MODE) |-> pins_float)
        else $error("pins released before exit ended");
    AST_TAP_QUIET: assert property (@(posedge TCK) disable iff (!RESET_N)
        tap_reset_walk |=> !TDO_OE)
        else $error("serial out enabled after port reset");
    AST_SHIFT_ENTRY: assert property (@(posedge TCK) disable iff (!RESET_N)
        $rose(TDO_OE) |-> !$past(TMS))
        else $error("shift entered with mode select high");
    AST_SHIFT_LEAVE: assert property (@(posedge TCK) disable iff (!RESET_N)
        $fell(TDO_OE) |-> $past(TMS))
        else $error("shift left with mode select low");
endmodule : jisp_seq_properties
bind jisp_sequencer jisp_seq_properties #(.ENTER_CYC(ENTER_CYC), .EXIT_CYC(EXIT_CYC)) u_props (
    .CLK(CLK), .RESET_N(RESET_N), .TCK(TCK), .TMS(TMS), .TDO_OE(TDO_OE),
    .IO_OE(IO_OE), .IO_PULLUP(IO_PULLUP), .PROG_MODE(PROG_MODE)
);

// [bench/jisp_programmer.sv]
// Behavioural programmer driving the test port from the far side
`timescale 1ns/1ps
module jisp_programmer (
    output logic TCK,
    output logic TMS,
    output logic TDI,
    input wire logic TDO
);
    import jisp_pkg::*;
    // ----------
    // Port tasks
    // ----------
    // Clock rests low between frames; TDI rests at its pulled-up level
    initial begin
        TCK = 1'b0;
        TMS = 1'b1;
        TDI = 1'b1;
    end
    // One 12 ns period; lines move only after the falling edge
    task automatic tick(input logic tms_v, input logic tdi_v, output logic tdo_v);
        TMS = tms_v;
        TDI = tdi_v;
        #6 TCK = 1'b1;
        tdo_v = TDO;
        #6 TCK = 1'b0;
    endtask : tick
    task automatic clocks(input logic tms_v, input int n);
        logic d;
        for (int i = 0; i < n; i++) begin
            tick(tms_v, 1'b1, d);
        end
    endtask : clocks
    // Idle to shift, n bits LSB first both ways, update, back to idle
    task automatic shift(input logic is_ir, input int n, input logic [31:0] din,
        output logic [31:0] dout);
        logic d;
        dout = '0;
        tick(1'b1, 1'b1, d);
        if (is_ir) begin
            tick(1'b1, 1'b1, d);
        end
        clocks(1'b0, 2);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], d);
            dout[i] = d;
        end
        tick(1'b1, 1'b1, d);
        tick(1'b0, 1'b1, d);
    endtask : shift
    // Bounded busy poll, so enter, exit and pulses get their full time
    task automatic poll(output logic [31:0] st);
        logic [31:0] x;
        shift(1'b1, IR_W, 32'(IR_STATUS), x);
        for (int i = 0; i < 3000; i++) begin
            shift(1'b0, 3, 32'h0, st);
            if (st[0] === 1'b0) break;
        end
    endtask : poll
endmodule : jisp_programmer

// [bench/jtag_insystem_program_sequencer_bench.sv]
// Bench: full, verify-only and cut-short passes against a behavioural model
`timescale 1ns/1ps
module jtag_insystem_program_sequencer_bench;
    import jisp_pkg::*;
    localparam int LIMIT = 60000;
    logic CLK;
    logic RESET_N;
    logic [IO_W-1:0] USER_DATA;
    logic [IO_W-1:0] USER_OE;
    wire logic TCK, TMS, TDI, TDO, TDO_OE, PROG_MODE;
    wire logic [IO_W-1:0] IO_OUT, IO_OE, IO_PULLUP;
    logic [DATA_W-1:0] mem_exp [256];
    logic [ADDR_W-1:0] addrs [7];
    logic [31:0] r;
    logic done_exp = 1'b0;
    logic freeze = 1'b0;
    int seed = 32'hbd3110a9;
    int miscompares = 0;
    int n_checks = 0;
    int fail_addr = -1;
    int cycles = 0;
    // ---------
    // Structure
    // ---------
    // Short enter, exit and erase times keep the run brief
    jisp_sequencer #(.ENTER_CYC(50), .EXIT_CYC(50), .ERASE_CYC(400)) dut (
        .CLK(CLK), .RESET_N(RESET_N), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO),
        .TDO_OE(TDO_OE), .USER_DATA(USER_DATA), .USER_OE(USER_OE), .IO_OUT(IO_OUT),
        .IO_OE(IO_OE), .IO_PULLUP(IO_PULLUP), .PROG_MODE(PROG_MODE)
    );
    jisp_programmer prog (.TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO));
    // System clock at 100 MHz
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    // Ceiling well past the expected run; a hang counts as a mismatch
    always @(posedge CLK) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            finish_test();
        end
    end
    // Core outputs wander unless a pin check has frozen them
    always @(posedge CLK) begin
        if (!freeze) begin
            USER_DATA <= 16'($random(seed));
            USER_OE <= 16'($random(seed));
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Pins either float with pull-up or follow the frozen core outputs
    task automatic chk_pins(input logic held);
        @(negedge CLK);
        freeze = 1'b1;
        repeat (3) @(posedge CLK);
        #1;
        chk("pin enable", held ? 32'h0 : 32'(USER_OE), 32'(IO_OE));
        chk("pin data", held ? 32'h0 : 32'(USER_DATA & USER_OE), 32'(IO_OUT & IO_OE));
        if (held) chk("pull-up", 32'hffff, 32'(IO_PULLUP));
        freeze = 1'b0;
    endtask : chk_pins
    // Instruction, busy poll, status against the model
    task automatic cmd(input logic [IR_W-1:0] code, input logic mode);
        prog.shift(1'b1, IR_W, 32'(code), r);
        chk("ir capture", 32'(IR_CAPTURE), r);
        prog.poll(r);
        chk("status", {29'h0, done_exp, mode, 1'b0}, r);
    endtask : cmd
    task automatic check_id;
        prog.shift(1'b1, IR_W, 32'(IR_IDCODE), r);
        prog.shift(1'b0, DR_W, 32'h0, r);
        chk("silicon id", SILICON_ID, r);
    endtask : check_id
    task automatic prog_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        prog.shift(1'b1, IR_W, 32'(IR_ADDRESS), r);
        prog.shift(1'b0, ADDR_W, 32'(a), r);
        prog.shift(1'b1, IR_W, 32'(IR_PROGRAM), r);
        prog.shift(1'b0, DATA_W, 32'(d), r);
        prog.poll(r);
        mem_exp[a] = d;
        done_exp = 1'b0;
        chk("status", 32'h2, r);
    endtask : prog_word
    // Read pulse is a fixed 100 cycles, so a 1200 ns pause covers it
    task automatic verify_all;
        for (int i = 0; i < 7; i++) begin
            prog.shift(1'b1, IR_W, 32'(IR_ADDRESS), r);
            prog.shift(1'b0, ADDR_W, 32'(addrs[i]), r);
            prog.shift(1'b1, IR_W, 32'(IR_READ), r);
            prog.clocks(1'b0, 100);
            prog.shift(1'b0, DATA_W, 32'h0, r);
            chk("read word", 32'(mem_exp[addrs[i]]), r);
            if (r !== 32'(mem_exp[addrs[i]]) && fail_addr < 0) fail_addr = addrs[i];
        end
    endtask : verify_all
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    // Fixed step sequence, no adaptation
    initial begin
        RESET_N = 1'b0;
        USER_DATA = '0;
        USER_OE = '0;
        fork
            repeat (20) @(posedge CLK);
            prog.clocks(1'b1, 12);
        join
        RESET_N <= 1'b1;
        prog.clocks(1'b1, 6);
        prog.clocks(1'b0, 1);
        chk_pins(1'b1);
        check_id();
        cmd(IR_ENTER, 1'b1);
        chk("mode flag", 32'h1, 32'(PROG_MODE));
        chk_pins(1'b1);
        check_id();
        foreach (mem_exp[i]) mem_exp[i] = ERASED_WORD;
        cmd(IR_ERASE, 1'b1);
        for (int i = 0; i < 7; i++) begin
            addrs[i] = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
        end
        for (int i = 0; i < 6; i++) prog_word(addrs[i], 16'($random(seed)));
        verify_all();
        done_exp = 1'b1;
        cmd(IR_DONE, 1'b1);
        chk_pins(1'b1);
        cmd(IR_EXIT, 1'b0);
        chk_pins(1'b0);
        cmd(IR_ERASE, 1'b0);
        cmd(IR_ENTER, 1'b1);
        check_id();
        verify_all();
        cmd(IR_EXIT, 1'b0);
        chk_pins(1'b0);
        cmd(IR_ENTER, 1'b1);
        done_exp = 1'b0;
        cmd(IR_ERASE, 1'b1);
        cmd(IR_EXIT, 1'b0);
        chk_pins(1'b1);
        chk("first failing address", 32'hffff_ffff, 32'(fail_addr));
        finish_test();
    end
endmodule : jtag_insystem_program_sequencer_bench
